// ===== core/pbpfs_pkg.sv
/*
 * Shared constants and types for the port B/C pin function select block:
 * register offsets, field positions, reset values and the operating mode.
 * Assumes a classic Wishbone slave port with 32-bit data, byte address.
 */
package pbpfs_pkg;

   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned REG_W   = 16;
   localparam int unsigned PIN_N   = 18;
   localparam int unsigned PORTC_N = 16;

   localparam logic [7:0] PB_CTRL_OFS = 8'h00;
   localparam logic [7:0] PC_DIR_OFS  = 8'h04;
   localparam logic [7:0] PC_FSEL_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS  = 8'h0C;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int unsigned PB0_MODE_BIT = 0;
   localparam int unsigned PB_RSVD_BIT  = 1;
   localparam int unsigned PB1_MODE_BIT = 2;
   localparam int unsigned PB0_PIN      = 16;
   localparam int unsigned PB1_PIN      = 17;
   localparam int unsigned STAT_MODE_LO = 24;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [1:0]  PB_MODE_RST = 2'h0;
   localparam logic [15:0] PC_DIR_RST  = 16'h0000;
   localparam logic [15:0] PC_FSEL_RST = 16'h0000;

   // ----------------------------------------------------------------------
   // operating mode, strapped from outside
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      PBPFS_MODE_ADDR_ONLY  = 2'b00,  // on-chip program memory disabled
      PBPFS_MODE_EXTENDED   = 2'b01,  // on-chip program memory enabled
      PBPFS_MODE_SINGLECHIP = 2'b10
   } pbpfs_opmode_t;

   typedef struct packed {
      logic [PIN_N-1:0] level;
      logic [PIN_N-1:0] enable;
      logic [PIN_N-1:0] isAddr;
   } pbpfs_pin_drive_t;

endpackage

// ===== core/pbpfs_pin_cell.sv
/*
 * One multiplexed pin: picks address output or general I/O and sets the
 * drive enable. Purely combinational; the top registers the results.
 * Assumes the operating mode and all inputs are synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module pbpfs_pin_cell
(
   input  wire pbpfs_pkg::pbpfs_opmode_t opMode,
   input  wire logic                     modeBit,
   input  wire logic                     dirBit,
   input  wire logic                     addrBit,
   input  wire logic                     gpioBit,
   output logic                          isAddr,
   output logic                          level,
   output logic                          enable
);

   // ----------------------------------------------------------------------
   // function decode
   // ----------------------------------------------------------------------
   wire forceAddr = (opMode == pbpfs_pkg::PBPFS_MODE_ADDR_ONLY);
   wire followReg = (opMode == pbpfs_pkg::PBPFS_MODE_EXTENDED);

   // unknown mode codes fall back to general I/O: never drive the bus
   assign isAddr = forceAddr | (followReg & modeBit);  // [R1] [R3] [R10] [R11]

   // direction only counts while the pin is general I/O
   assign level  = isAddr ? addrBit : gpioBit;
   assign enable = isAddr | dirBit;  // [R5] [R6]

endmodule

`default_nettype wire

// ===== core/pbpfs_top.sv
/*
 * Port B pins 0/1 and port C pins 0..15 function and direction select,
 * with its registers on a classic Wishbone slave.
 * Assumes rst is the power-on reset; the watchdog, standby and sleep
 * signals come from the system controller and leave registers alone.
 */
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R1] Port B pin1 mode bit at 2 picks GPIO at 0 and address 17 at 1, forced by mode.
// [R2] Port B control bit 1 always reads 0 and software writes 0 to it.
// [R3] Port B pin0 mode bit at 0 picks GPIO at 0 and address 16 at 1, forced by mode.
// [R4] The port C direction register is 16 bits read/write, bit n for pin n.
// [R5] A GPIO port C pin is driven when its direction bit is 1, input when 0.
// [R6] A direction bit is ignored while its pin carries an address output.
// [R7] The direction register clears only on power-on reset and keeps data otherwise.
// [R8] The port C function register is 16 bits read/write, mode may override it.
// [R9] The function register clears only on power-on reset and keeps data otherwise.
// [R10] Port C mode bit n picks GPIO at 0 and address n at 1, forced by mode.
// [R11] With on-chip program memory enabled the pin follows its mode bit directly.
module pbpfs_top
(
   input  wire logic                             clk_sys,
   input  wire logic                             rst,
   input  wire logic                             wdtRst,
   input  wire logic                             standbyMode,
   input  wire logic                             sleepMode,
   input  wire pbpfs_pkg::pbpfs_opmode_t         opMode,
   input  wire logic                             wb_cyc_i,
   input  wire logic                             wb_stb_i,
   input  wire logic                             wb_we_i,
   input  wire logic [pbpfs_pkg::ADDR_W-1:0]     wb_adr_i,
   input  wire logic [3:0]                       wb_sel_i,
   input  wire logic [pbpfs_pkg::DATA_W-1:0]     wb_dat_i,
   output logic [pbpfs_pkg::DATA_W-1:0]          wb_dat_o,
   output logic                                  wb_ack_o,
   input  wire logic [pbpfs_pkg::PIN_N-1:0]      addrBus,
   input  wire logic [pbpfs_pkg::PORTC_N-1:0]    portcDataOut,
   input  wire logic [1:0]                       portbDataOut,
   input  wire logic [1:0]                       portbDir,
   input  wire logic [pbpfs_pkg::PIN_N-1:0]      pinIn,
   output logic [pbpfs_pkg::PIN_N-1:0]           pinOut,
   output logic [pbpfs_pkg::PIN_N-1:0]           pinOe,
   output logic [pbpfs_pkg::PIN_N-1:0]           gpioIn
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic [1:0]                         pbModeQ;
   logic [pbpfs_pkg::REG_W-1:0]        pcDirQ;
   logic [pbpfs_pkg::REG_W-1:0]        pcFselQ;
   logic                               ackQ;
   logic [pbpfs_pkg::DATA_W-1:0]       datQ;
   logic [pbpfs_pkg::PIN_N-1:0]        pinOutQ;
   logic [pbpfs_pkg::PIN_N-1:0]        pinOeQ;
   logic [pbpfs_pkg::PIN_N-1:0]        gpioInQ;
   wire pbpfs_pkg::pbpfs_pin_drive_t   drive;

   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   wire take    = wb_cyc_i & wb_stb_i & ~ackQ;
   wire wrTake  = take & wb_we_i;
   wire hitPb   = (wb_adr_i[7:2] == pbpfs_pkg::PB_CTRL_OFS[7:2]);
   wire hitDir  = (wb_adr_i[7:2] == pbpfs_pkg::PC_DIR_OFS[7:2]);
   wire hitFsel = (wb_adr_i[7:2] == pbpfs_pkg::PC_FSEL_OFS[7:2]);
   wire hitStat = (wb_adr_i[7:2] == pbpfs_pkg::STATUS_OFS[7:2]);
   wire wrPb    = wrTake & hitPb & wb_sel_i[0];
   wire wrDir   = wrTake & hitDir;
   wire wrFsel  = wrTake & hitFsel;

   // byte lanes merged into the 16-bit registers
   wire [15:0] laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [15:0] dirNext  = (wb_dat_i[15:0] & laneMask) | (pcDirQ & ~laneMask);
   wire [15:0] fselNext = (wb_dat_i[15:0] & laneMask) | (pcFselQ & ~laneMask);
   wire [1:0]  pbNext   = {wb_dat_i[pbpfs_pkg::PB1_MODE_BIT],
                           wb_dat_i[pbpfs_pkg::PB0_MODE_BIT]};

   // reserved bit 1 is not stored, so it can only read back as 0
   wire [31:0] pbWord   = {29'h0, pbModeQ[1], 1'b0, pbModeQ[0]};  // [R2]
   wire [31:0] dirWord  = {16'h0, pcDirQ};  // [R4]
   wire [31:0] fselWord = {16'h0, pcFselQ};  // [R8]
   wire [31:0] statWord = {6'h0, opMode, 6'h0, drive.isAddr};

   // unmapped addresses answer with zero data and ignore writes
   wire [31:0] rdMux = hitPb   ? pbWord   :
                       hitDir  ? dirWord  :
                       hitFsel ? fselWord :
                       hitStat ? statWord : 32'h0000_0000;

   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------
   // only power-on reset clears them; watchdog, standby and sleep keep them
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pbModeQ <= pbpfs_pkg::PB_MODE_RST;
         pcDirQ  <= pbpfs_pkg::PC_DIR_RST;  // [R7]
         pcFselQ <= pbpfs_pkg::PC_FSEL_RST;  // [R9]
      end
      else
      begin
         if (wrPb)
            pbModeQ <= pbNext;  // [R1] [R3]
         if (wrDir)
            pcDirQ <= dirNext;  // [R4]
         if (wrFsel)
            pcFselQ <= fselNext;  // [R8]
      end
   end

   // ----------------------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------------------
   // a watchdog reset drops a pending answer but never the register data
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ackQ <= 1'b0;
         datQ <= 32'h0000_0000;
      end
      else
      begin
         ackQ <= take & ~wdtRst;
         if (take & ~wb_we_i)
            datQ <= rdMux;
      end
   end

   assign wb_ack_o = ackQ;
   assign wb_dat_o = datQ;

   // ----------------------------------------------------------------------
   // pin cells
   // ----------------------------------------------------------------------
   wire [17:0] modeVec = {pbModeQ, pcFselQ};
   wire [17:0] dirVec  = {portbDir, pcDirQ};
   wire [17:0] gpioVec = {portbDataOut, portcDataOut};

   genvar gi;
   generate
      for (gi = 0; gi < pbpfs_pkg::PIN_N; gi++)
      begin : g_pin
         pbpfs_pin_cell u_cell
         (
            .opMode  (opMode),
            .modeBit (modeVec[gi]),
            .dirBit  (dirVec[gi]),
            .addrBit (addrBus[gi]),
            .gpioBit (gpioVec[gi]),
            .isAddr  (drive.isAddr[gi]),
            .level   (drive.level[gi]),
            .enable  (drive.enable[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // pin registers
   // ----------------------------------------------------------------------
   // one cycle of latency buys clean, glitch-free pad drive
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pinOutQ <= 18'h00000;
         pinOeQ  <= 18'h00000;
         gpioInQ <= 18'h00000;
      end
      else
      begin
         pinOutQ <= drive.level;  // [R5]
         pinOeQ  <= drive.enable;  // [R5] [R6]
         gpioInQ <= pinIn;
      end
   end

   assign pinOut = pinOutQ;
   assign pinOe  = pinOeQ;
   assign gpioIn = gpioInQ;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   wire lowPower = standbyMode | sleepMode | wdtRst;

   // pins still hold reset values one edge after release
   a_pb1_addr_forced: assert property ( // [R1]
      !$past(rst) && opMode == pbpfs_pkg::PBPFS_MODE_ADDR_ONLY
      |=> pinOe[17] && pinOut[17] == $past(addrBus[17]))
      else $error("pb pin1 not address in address-only mode");

   a_pb1_single_gpio: assert property ( // [R1]
      opMode == pbpfs_pkg::PBPFS_MODE_SINGLECHIP && !portbDir[1]
      |=> !pinOe[17])
      else $error("pb pin1 driven in single-chip mode as input");

   a_pb_rsvd_zero: assert property ( // [R2]
      take && !wb_we_i && !wdtRst && hitPb
      |=> wb_ack_o && wb_dat_o[1] == 1'b0)
      else $error("reserved port b bit read nonzero");

   a_pb0_follow_bit: assert property ( // [R3]
      opMode == pbpfs_pkg::PBPFS_MODE_EXTENDED && pbModeQ[0]
      |=> pinOe[16] && pinOut[16] == $past(addrBus[16]))
      else $error("pb pin0 not address when mode bit set");

   a_dir_write_back: assert property ( // [R4]
      wrDir && wb_sel_i[1:0] == 2'b11 |=> pcDirQ == $past(wb_dat_i[15:0]))
      else $error("direction register did not take write");

   a_gpio_dir_drive: assert property ( // [R5]
      opMode == pbpfs_pkg::PBPFS_MODE_SINGLECHIP
      |=> pinOe[15:0] == $past(pcDirQ)
          && pinOut[3] == $past(portcDataOut[3]))
      else $error("gpio drive does not follow direction");

   a_dir_ignored_addr: assert property ( // [R6]
      !$past(rst) && opMode == pbpfs_pkg::PBPFS_MODE_ADDR_ONLY ##1 !rst
      |-> pinOe[15:0] == 16'hFFFF)
      else $error("address pin released by direction bit");

   a_dir_kept_lowpwr: assert property ( // [R7]
      lowPower && !wrDir |=> $stable(pcDirQ))
      else $error("direction lost in low power or watchdog reset");

   a_fsel_write_back: assert property ( // [R8]
      wrFsel && wb_sel_i[1:0] == 2'b11 |=> pcFselQ == $past(wb_dat_i[15:0]))
      else $error("function register did not take write");

   a_fsel_kept_lowpwr: assert property ( // [R9]
      lowPower && !wrFsel |=> $stable(pcFselQ))
      else $error("function select lost in low power or watchdog reset");

   a_pc_mode_select: assert property ( // [R10]
      opMode == pbpfs_pkg::PBPFS_MODE_EXTENDED && pcFselQ[15]
      |=> pinOe[15] && pinOut[15] == $past(addrBus[15]))
      else $error("port c pin15 not address when mode bit set");

   a_ext_follows_reg: assert property ( // [R11]
      opMode == pbpfs_pkg::PBPFS_MODE_EXTENDED && $stable(pcFselQ)
      |-> drive.isAddr[15:0] == pcFselQ)
      else $error("extended mode overrides function bits");

   a_ack_one_cycle: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_ack_after_take: assert property (
      take && !wdtRst |=> wb_ack_o)
      else $error("taken request not answered next cycle");

   // a watchdog reset in the taken cycle swallows the ack; held stb retries
   a_wdt_drops_ack: assert property (
      take && wdtRst |=> !wb_ack_o)
      else $error("ack given for request taken under watchdog reset");

   a_unmapped_read_zero: assert property (
      take && !wb_we_i && !wdtRst && wb_adr_i[7:4] != 4'h0
      |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");

   a_pb_write_back: assert property ( // [R1] [R3]
      wrPb |=> pbModeQ == {$past(wb_dat_i[pbpfs_pkg::PB1_MODE_BIT]),
                           $past(wb_dat_i[pbpfs_pkg::PB0_MODE_BIT])})
      else $error("port b mode bits did not take write");

   a_single_no_addr: assert property ( // [R1] [R3] [R10]
      opMode == pbpfs_pkg::PBPFS_MODE_SINGLECHIP |-> drive.isAddr == 18'h00000)
      else $error("address function selected in single-chip mode");

   a_addr_only_all: assert property ( // [R1] [R3] [R10]
      opMode == pbpfs_pkg::PBPFS_MODE_ADDR_ONLY |-> drive.isAddr == 18'h3FFFF)
      else $error("general i/o selected in address-only mode");

   c_read_dir: cover property (
      take && !wb_we_i && hitDir ##1 wb_ack_o);

   c_gpio_out: cover property (
      opMode == pbpfs_pkg::PBPFS_MODE_EXTENDED && pcDirQ[0] && !pcFselQ[0]
      ##1 pinOe[0]);

   c_addr_pin: cover property (
      opMode == pbpfs_pkg::PBPFS_MODE_EXTENDED && pbModeQ[1] ##1 pinOe[17]);

   c_wdt_keep: cover property (
      wdtRst && pcFselQ != 16'h0000);

   c_wdt_retry: cover property (
      take && wdtRst ##1 take);

endmodule

`default_nettype wire

// ===== tb/pbpfs_pin_load.sv
/*
 * Far-side model of the port B/C pads: the external loads on each pin.
 * Assumes pinOe high means the block drives the pad; no pull resistors.
 */
`timescale 1ns/1ps
`default_nettype none

module pbpfs_pin_load
(
   input  wire logic                         clk_sys,
   input  wire logic [pbpfs_pkg::PIN_N-1:0]  pinOut,
   input  wire logic [pbpfs_pkg::PIN_N-1:0]  pinOe,
   output logic [pbpfs_pkg::PIN_N-1:0]       pinIn
);
   // ----------------------------------------------------------------------
   // pad levels
   // ----------------------------------------------------------------------
   // undriven pads toggle every cycle, so a stale value never looks right
   logic [pbpfs_pkg::PIN_N-1:0] floatQ = 18'h2AAAA;

   always @(posedge clk_sys)
      floatQ <= ~floatQ;

   assign pinIn = (pinOe & pinOut) | (~pinOe & floatQ);
endmodule

`default_nettype wire

// ===== tb/testbench.sv
/*
 * Self-checking bench for pbpfs_top: Wishbone register accesses and
 * pin function checks in every operating mode.
 * Assumes the pad load model and a 20 MHz clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: %h / %h", $time, (a), (b)); end end

module testbench;
   logic                    clk_sys     = 1'b0;
   logic                    rst         = 1'b1;
   logic                    wdtRst      = 1'b0;
   logic                    standbyMode = 1'b0;
   logic                    sleepMode   = 1'b0;
   pbpfs_pkg::pbpfs_opmode_t opMode     = pbpfs_pkg::PBPFS_MODE_ADDR_ONLY;
   logic                    cyc         = 1'b0;
   logic                    stb         = 1'b0;
   logic                    we          = 1'b0;
   logic [7:0]              adr         = 8'h00;
   logic [3:0]              sel         = 4'h0;
   logic [31:0]             datI        = 32'h00000000;
   logic [31:0]             datO;
   logic                    ack;
   logic [17:0]             addrBus     = 18'h2C5A3;
   logic [15:0]             pcOut       = 16'h3C96;
   logic [1:0]              pbOut       = 2'h2;
   logic [1:0]              pbDir       = 2'h1;
   logic [17:0]             pinIn;
   logic [17:0]             pinOut;
   logic [17:0]             pinOe;
   logic [17:0]             gpioIn;
   logic [15:0]             pbQ         = 16'h0000;
   logic [15:0]             dirQ        = 16'h0000;
   logic [15:0]             fselQ       = 16'h0000;
   int                      errors      = 0;
   int                      cmp_count   = 0;

   always #25 clk_sys = ~clk_sys;

   pbpfs_top i_pbpfs_top (.clk_sys(clk_sys), .rst(rst), .wdtRst(wdtRst),
      .standbyMode(standbyMode), .sleepMode(sleepMode), .opMode(opMode),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
      .addrBus(addrBus), .portcDataOut(pcOut), .portbDataOut(pbOut),
      .portbDir(pbDir), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .gpioIn(gpioIn));

   pbpfs_pin_load i_pbpfs_pin_load (.clk_sys(clk_sys), .pinOut(pinOut),
      .pinOe(pinOe), .pinIn(pinIn));

   // ----------------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------------
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
      @(posedge clk_sys);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      datI <= d;
      // only the watchdog process ends a wait that never sees ack
      do
         @(posedge clk_sys);
      while (ack !== 1'b1);
      q = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic [31:0] q;
      wb(1'b1, a, d, s, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h00000000, 4'hF, q);
      `CHK(q, e)
   endtask

   // ----------------------------------------------------------------------
   // pin checks
   // ----------------------------------------------------------------------
   task automatic chkPins(input logic [1:0] m);
      logic [17:0] isA;
      logic [17:0] eOe;
      logic [17:0] eOut;
      @(posedge clk_sys);
      opMode  <= pbpfs_pkg::pbpfs_opmode_t'(m);
      addrBus <= 18'h2C5A3 ^ {9{m}};
      pcOut   <= 16'h3C96 ^ {8{~m}};
      repeat (3) @(posedge clk_sys);
      // mode 11 is taken as single chip
      isA  = (m == 2'h0) ? '1 : (m == 2'h1) ? {pbQ[2], pbQ[0], fselQ} : '0;
      eOe  = isA | {pbDir, dirQ};
      eOut = (isA & addrBus) | (~isA & {pbOut, pcOut});
      @(negedge clk_sys);
      `CHK(pinOe, eOe)
      `CHK(pinOut, eOut)
      `CHK(gpioIn & eOe, pinOut & eOe)
      rdc(8'h0C, {6'h00, m, 6'h00, isA});
   endtask

   task automatic complete_run;
      if (errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      #(50 * 5000);
      errors++;
      complete_run();
   end

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rdc(8'h00, 32'h00000000);
      rdc(8'h04, 32'h00000000);
      rdc(8'h08, 32'h00000000);
      chkPins(2'h0);
      wr(8'h00, 32'h00000005, 4'h1);
      pbQ = 16'h0005;
      rdc(8'h00, 32'h00000005);
      wr(8'h04, 32'h0000A5C3, 4'h3);
      wr(8'h04, 32'h00001234, 4'h2);
      dirQ = 16'h12C3;
      rdc(8'h04, 32'h000012C3);
      wr(8'h08, 32'h0000F00F, 4'h3);
      fselQ = 16'hF00F;
      rdc(8'h08, 32'h0000F00F);
      wr(8'h10, 32'hFFFFFFFF, 4'hF);
      rdc(8'h10, 32'h00000000);
      for (int m = 0; m < 4; m++)
         chkPins(m[1:0]);
      wr(8'h00, 32'h00000001, 4'h1);
      pbQ = 16'h0001;
      chkPins(2'h1);
      // retention across watchdog reset, standby and sleep
      @(posedge clk_sys);
      wdtRst      <= 1'b1;
      standbyMode <= 1'b1;
      sleepMode   <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // a read taken under watchdog reset is retried and still answers
      fork
         rdc(8'h04, 32'h000012C3);
         begin
            repeat (2) @(posedge clk_sys);
            wdtRst      <= 1'b0;
            standbyMode <= 1'b0;
            sleepMode   <= 1'b0;
         end
      join
      rdc(8'h08, 32'h0000F00F);
      rdc(8'h00, 32'h00000001);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      pbQ   = 16'h0000;
      dirQ  = 16'h0000;
      fselQ = 16'h0000;
      rdc(8'h04, 32'h00000000);
      rdc(8'h08, 32'h00000000);
      chkPins(2'h2);
      complete_run();
   end
endmodule

`undef CHK
`default_nettype wire
